// ===== amp_i2c_host.sv
/*
  Host controller model: a bus master that writes and reads registers.
  Assumes a pulled-up data wire and a clock at 8 ns, 8 cycles per bus phase, 24 per bit.
*/
`timescale 1ns/100ps
`default_nettype none
module amp_i2c_host
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_oe_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic half();
      repeat (8) @(negedge clk_i);
   endtask
   task automatic start();
      sda_oe_o = 1'b0; half(); scl_o = 1'b1; half(); sda_oe_o = 1'b1; half(); scl_o = 1'b0; half();
   endtask
   task automatic stop();
      sda_oe_o = 1'b1; half(); scl_o = 1'b1; half(); sda_oe_o = 1'b0; half();
   endtask
   task automatic xbit(input logic b, output logic r);
      sda_oe_o = !b; half(); scl_o = 1'b1; half(); r = sda_i; scl_o = 1'b0; half();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(a, r);
      ack = !r;
   endtask
   task automatic wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d [$], output logic ok);
      logic [7:0] q;
      logic       a;
      start(); xbyte(dev, 1'b1, q, ok); xbyte(sub, 1'b1, q, a); ok &= a;
      foreach (d[i])
      begin
         xbyte(d[i], 1'b1, q, a);
         ok &= a;
      end
      stop();
   endtask
   task automatic rd(input logic [7:0] dev, input logic [7:0] sub, input int n, output logic [7:0] q [$],
                     output logic ok);
      logic [7:0] b;
      logic       a;
      q = {};
      start(); xbyte(dev, 1'b1, b, ok); xbyte(sub, 1'b1, b, a); ok &= a;
      start(); xbyte(dev | 8'h01, 1'b1, b, a); ok &= a;
      for (int i = 0; i < n; i++)
      begin
         xbyte(8'hFF, i == n - 1, b, a);
         q.push_back(b);
      end
      stop();
   endtask
endmodule // amp_i2c_host
`default_nettype wire

// ===== amp_i2c_slave.sv
/*
  Byte level I2C slave: address match, subaddress, auto-increment
  on sequential reads and writes, write strobe and read data fetch.
  Assumes scl_i and sda_i are already synchronised to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module amp_i2c_slave
   import amp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       en_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [6:0] dev_addr_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] sub_o,
   output reg_wr_t         wr_o,
   output logic            sda_oe_o
);

   localparam slv_t SLV_INIT = '{st: I_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};

   slv_t s_ff;
   slv_t nxt_s;
   logic rise;
   logic fall;

   assign rise     = scl_i & ~s_ff.scl_p;
   assign fall     = ~scl_i & s_ff.scl_p;
   assign sub_o    = s_ff.sub;
   assign wr_o     = s_ff.wr;
   assign sda_oe_o = s_ff.oe;

   always_comb
   begin
      nxt_s       = s_ff;
      nxt_s.scl_p = scl_i;
      nxt_s.sda_p = sda_i;
      nxt_s.wr.wr = 1'b0;
      if (scl_i && s_ff.scl_p && s_ff.sda_p && !sda_i)
      begin
         // Start or repeated start; subaddress survives a repeated start
         nxt_s.st       = I_RX;
         nxt_s.cnt      = 4'h0;
         nxt_s.is_addr  = 1'b1;
         nxt_s.sub_pend = 1'b1;
         nxt_s.oe       = 1'b0;
      end
      else if (scl_i && s_ff.scl_p && !s_ff.sda_p && sda_i)
      begin
         nxt_s.st = I_IDLE;
         nxt_s.oe = 1'b0;
      end
      else
      begin
         case (s_ff.st)
            I_RX:
            begin
               if (rise)
               begin
                  nxt_s.sh  = {s_ff.sh[6:0], sda_i};
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               end
               else if (fall && s_ff.cnt == 4'h8)
               begin
                  nxt_s.cnt = 4'h0;
                  nxt_s.st  = I_RX_ACK;
                  nxt_s.oe  = 1'b1;
                  if (s_ff.is_addr)
                  begin
                     nxt_s.is_addr = 1'b0;
                     nxt_s.rw      = s_ff.sh[0];
                     if (s_ff.sh[7:1] != dev_addr_i)
                     begin
                        nxt_s.st = I_IDLE;
                        nxt_s.oe = 1'b0;
                     end
                  end
                  else if (s_ff.sub_pend)
                  begin
                     nxt_s.sub      = s_ff.sh;
                     nxt_s.sub_pend = 1'b0;
                  end
                  else
                  begin
                     nxt_s.wr  = '{wr: 1'b1, addr: s_ff.sub, data: s_ff.sh};
                     nxt_s.sub = s_ff.sub + 8'h01;
                  end
               end
            end
            I_RX_ACK:
            begin
               if (fall)
               begin
                  nxt_s.oe = 1'b0;
                  nxt_s.st = I_RX;
                  if (s_ff.rw)
                  begin
                     nxt_s.st  = I_TX;
                     nxt_s.sh  = rdata_i;
                     nxt_s.oe  = ~rdata_i[7];
                     nxt_s.cnt = 4'h1;
                  end
               end
            end
            I_TX:
            begin
               if (fall)
               begin
                  if (s_ff.cnt == 4'h8)
                  begin
                     nxt_s.oe = 1'b0;
                     nxt_s.st = I_TX_ACK;
                  end
                  else
                  begin
                     nxt_s.oe  = ~s_ff.sh[6];
                     nxt_s.sh  = {s_ff.sh[6:0], 1'b0};
                     nxt_s.cnt = s_ff.cnt + 4'h1;
                  end
               end
            end
            I_TX_ACK:
            begin
               if (rise)
               begin
                  // Not-acknowledge ends the read; acknowledge fetches the next byte
                  nxt_s.st  = sda_i ? I_IDLE : I_RX_ACK;
                  nxt_s.sub = s_ff.sub + 8'h01;
               end
            end
            default:
            begin
               nxt_s.st = I_IDLE;
               nxt_s.oe = 1'b0;
            end
         endcase
      end
      if (!en_i)
      begin
         nxt_s = SLV_INIT;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s_ff <= SLV_INIT;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

endmodule // amp_i2c_slave

`default_nettype wire

// ===== amp_mode_fault_pin_control.sv
/*
  Mode and fault supervisor of a four-channel class-D amplifier: fault and
  clip/heat-warning open-drain pins, mute and standby pins, mute ramps,
  switching frequency select and the I2C register set.
  Assumes all analog monitors and pins are asynchronous to clk_i, and that
  addr_sel_i already carries the decoded level of the address-select pin.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amp_params.svh"

module amp_mode_fault_pin_control
   import amp_pkg::*;
#(
   parameter int CM_CYC   = `CM_RAMP_MS * `CLK_KHZ,
   parameter int STEP_CYC = `GAIN_RAMP_MS * `CLK_KHZ / `GAIN_STEPS,
   parameter int STBY_CYC = `STBY_MS * `CLK_KHZ
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [1:0] addr_sel_i,
   input  wire logic       mute_n_i,
   input  wire logic       standby_n_i,
   input  wire logic       por_i,
   input  wire logic       uv_i,
   input  wire logic       cp_uv_i,
   input  wire logic       ov_i,
   input  wire logic       otsd_i,
   input  wire logic       heat_warning_i,
   input  wire logic       foldback_i,
   input  wire logic       clip_i,
   input  wire logic       tweeter_i,
   input  wire logic [3:0] oc_i,
   input  wire logic [3:0] dc_i,
   output logic            fault_o,
   output logic            fault_oe_o,
   output logic            clip_heat_warn_pin_o,
   output logic            clip_heat_warn_pin_oe_o,
   output logic            fsw_500k_o,
   output logic            osc_sync_master_o,
   output logic      [3:0] chan_hiz_o,
   output logic      [7:0] gain_level_o,
   output logic            standby_o
);

   typedef struct packed {
      pins_t      s1;
      pins_t      s2;
      logic [7:0] ctrl3;
      logic [7:0] ctrl5;
      logic [7:0] flt1;
      logic [7:0] flt2;
      ramp_st_t   rs;
      logic [21:0] cnt;
      logic [16:0] scnt;
      logic [7:0] level;
      logic       stby;
      logic       fault_oe;
      logic       warn_oe;
      logic [3:0] hiz;
   } top_t;

   localparam top_t TOP_INIT = '{s1: `PINS_IDLE, s2: `PINS_IDLE, ctrl3: `CTRL3_RST,
                                 ctrl5: `CTRL5_RST, flt1: `FAULT_RST, flt2: `FAULT_RST,
                                 rs: R_OFF, hiz: 4'hF, default: '0};

   top_t       s_ff;
   top_t       nxt_s;
   pins_t      p;
   pins_t      raw;
   reg_wr_t    wr;
   logic [7:0] sub;
   logic [7:0] rdata;
   logic       stby_req;
   logic       glob_flt;
   logic       clr;
   logic       play_req;
   logic       en;
   logic [3:0] hiz_eff;
   logic [7:0] set1;
   logic [7:0] set2;
   logic       warn_act;
   clip_mode_t mode;

   assign raw = '{scl: scl_i, sda: sda_i, mute_n: mute_n_i, stby_n: standby_n_i, por: por_i,
                  uv: uv_i, cp_uv: cp_uv_i, ov: ov_i, otsd: otsd_i, warn: heat_warning_i,
                  fold: foldback_i, clip: clip_i, tweet: tweeter_i, oc: oc_i, dc: dc_i,
                  addr_sel: addr_sel_i};
   assign p        = s_ff.s2;
   assign stby_req = ~p.stby_n | p.por;
   assign en       = ~stby_req;
   // Live levels too, so a global fault still hard-mutes while standby clears the latches
   assign glob_flt = |{s_ff.flt1[`F1_OV], s_ff.flt1[`F1_UV], s_ff.flt1[`F1_CPUV],
                       s_ff.flt1[`F1_OTSD], p.ov, p.uv, p.cp_uv, p.otsd} | p.por;
   assign clr      = wr.wr && wr.addr == `OFS_CTRL5 && wr.data[`C5_CLR];
   assign hiz_eff  = s_ff.ctrl5[3:0] | s_ff.flt2[3:0] | s_ff.flt2[7:4] | {4{glob_flt}};
   assign play_req = p.mute_n & ~stby_req & ~&hiz_eff;
   assign mode     = clip_mode_t'(s_ff.ctrl3[`C3_CLIP_LSB +: 2]);

   assign set1 = {p.ov, p.uv, 1'b0, p.cp_uv, p.otsd, |p.oc, |p.dc, 1'b0};
   assign set2 = {p.dc, p.oc};

   always_comb
   begin
      case (sub)
         `OFS_FAULT1: rdata = s_ff.flt1;
         `OFS_FAULT2: rdata = s_ff.flt2;
         `OFS_STAT1:  rdata = {1'b0, p.fold, p.warn, 3'h0, p.tweet, p.clip};
         `OFS_STAT2:  rdata = {4'h0, s_ff.hiz};
         `OFS_STAT3:  rdata = s_ff.level;
         `OFS_CTRL3:  rdata = s_ff.ctrl3;
         `OFS_CTRL5:  rdata = {4'h0, s_ff.ctrl5[3:0]};
         default:     rdata = 8'h00;
      endcase
   end

   always_comb
   begin
      case (mode)
         CLIP_ONLY: warn_act = p.clip;
         CLIP_BOTH: warn_act = p.clip | p.warn | p.fold;
         default:   warn_act = p.warn | p.fold;
      endcase
      if (s_ff.ctrl3[`C3_TWEET] && p.tweet)
      begin
         warn_act = 1'b1;
      end
   end

   always_comb
   begin
      nxt_s    = s_ff;
      nxt_s.s1 = raw;
      nxt_s.s2 = s_ff.s1;
      if (wr.wr && wr.addr == `OFS_CTRL3)
      begin
         nxt_s.ctrl3 = wr.data;
      end
      if (wr.wr && wr.addr == `OFS_CTRL5)
      begin
         nxt_s.ctrl5 = {4'h0, wr.data[3:0]};
      end
      // Set wins over the fault-reset command in the same cycle
      nxt_s.flt1 = (s_ff.flt1 & ~{8{clr}}) | set1;
      nxt_s.flt2 = (s_ff.flt2 & ~{8{clr}}) | set2;
      nxt_s.hiz  = hiz_eff | {4{s_ff.rs == R_OFF}};
      case (s_ff.rs)
         R_OFF:
         begin
            nxt_s.level = 8'h00;
            nxt_s.cnt   = 22'h0;
            if (play_req)
            begin
               nxt_s.rs = R_CM;
            end
         end
         R_CM:
         begin
            nxt_s.cnt = s_ff.cnt + 22'h1;
            if (!play_req)
            begin
               nxt_s.rs = R_OFF;
            end
            else if (s_ff.cnt == 22'(CM_CYC - 1))
            begin
               nxt_s.rs  = R_UP;
               nxt_s.cnt = 22'h0;
            end
         end
         R_UP, R_DN:
         begin
            nxt_s.cnt = s_ff.cnt + 22'h1;
            if ((s_ff.rs == R_UP) != play_req)
            begin
               nxt_s.rs  = play_req ? R_UP : R_DN;
               nxt_s.cnt = 22'h0;
            end
            else if (s_ff.cnt == 22'(STEP_CYC - 1))
            begin
               nxt_s.cnt = 22'h0;
               if (s_ff.rs == R_UP)
               begin
                  nxt_s.level = s_ff.level + 8'h01;
                  if (s_ff.level == 8'hFE)
                  begin
                     nxt_s.rs = R_PLAY;
                  end
               end
               else
               begin
                  nxt_s.level = s_ff.level - 8'h01;
                  if (s_ff.level == 8'h01)
                  begin
                     nxt_s.rs = R_OFF;
                  end
               end
            end
         end
         R_PLAY:
         begin
            nxt_s.cnt = 22'h0;
            if (!play_req)
            begin
               nxt_s.rs = R_DN;
            end
         end
         default:
         begin
            nxt_s.rs = R_OFF;
         end
      endcase
      if (glob_flt)
      begin
         nxt_s.rs    = R_OFF;
         nxt_s.level = 8'h00;
      end
      if (stby_req)
      begin
         nxt_s.ctrl3 = `CTRL3_RST;
         nxt_s.ctrl5 = `CTRL5_RST;
         nxt_s.flt1  = `FAULT_RST;
         nxt_s.flt2  = `FAULT_RST;
         if (s_ff.rs == R_OFF && s_ff.scnt != 17'(STBY_CYC))
         begin
            nxt_s.scnt = s_ff.scnt + 17'h1;
         end
      end
      else
      begin
         nxt_s.scnt = 17'h0;
      end
      nxt_s.stby     = stby_req && (p.por || s_ff.scnt == 17'(STBY_CYC));
      nxt_s.fault_oe = |s_ff.flt1 | |s_ff.flt2 | p.por;
      nxt_s.warn_oe  = warn_act;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s_ff <= TOP_INIT;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   amp_i2c_slave u_slave (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .en_i       (en),
      .scl_i      (p.scl),
      .sda_i      (p.sda),
      .dev_addr_i (`DEV_ADDR_BASE | {5'h00, p.addr_sel}),
      .rdata_i    (rdata),
      .sub_o      (sub),
      .wr_o       (wr),
      .sda_oe_o   (sda_oe_o)
   );

   assign sda_o                   = 1'b0;
   assign fault_o                 = 1'b0;
   assign fault_oe_o              = s_ff.fault_oe;
   assign clip_heat_warn_pin_o    = 1'b0;
   assign clip_heat_warn_pin_oe_o = s_ff.warn_oe;
   assign fsw_500k_o              = s_ff.ctrl3[`C3_FSW];
   assign osc_sync_master_o       = p.addr_sel == 2'b00;
   assign chan_hiz_o              = s_ff.hiz;
   assign gain_level_o            = s_ff.level;
   assign standby_o               = s_ff.stby;

endmodule // amp_mode_fault_pin_control

`default_nettype wire

// ===== amp_mode_fault_sva.sv
/*
  Pin-level assertions of the amplifier mode and fault supervisor.
  Assumes it is bound to the top module and shares its ramp parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module amp_mode_fault_sva
#(
   parameter int STEP_CYC = 2,
   parameter int STBY_CYC = 10
)
(
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       scl_i,
   input wire logic       sda_oe_o,
   input wire logic [1:0] addr_sel_i,
   input wire logic       mute_n_i,
   input wire logic       standby_n_i,
   input wire logic       por_i,
   input wire logic       uv_i,
   input wire logic       cp_uv_i,
   input wire logic       ov_i,
   input wire logic       otsd_i,
   input wire logic       fault_oe_o,
   input wire logic       osc_sync_master_o,
   input wire logic [3:0] chan_hiz_o,
   input wire logic [7:0] gain_level_o,
   input wire logic       standby_o
);
   localparam int SB_MAX = 255 * STEP_CYC + STBY_CYC + 16;
   int   sb_cnt_ff;
   logic glob;
   assign glob = ov_i | uv_i | cp_uv_i | otsd_i | por_i;
   // Cycles spent with the standby pin low and standby not yet reached
   always_ff @(posedge clk_i)
      if (!rst_n_i || standby_n_i || standby_o)
         sb_cnt_ff <= 0;
      else
         sb_cnt_ff <= sb_cnt_ff + 1;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_fault_pin_set: assert property ($rose(glob) && standby_n_i |-> ##[1:5] fault_oe_o)
      else $error("fault pin missed a fault");
   a_fault_hard_mute: assert property ($rose(glob) |-> ##[1:5] (gain_level_o == 8'h00 && chan_hiz_o == 4'hF))
      else $error("global fault did not silence channels");
   a_gain_unit_step: assert property ($changed(gain_level_o) |->
      gain_level_o == $past(gain_level_o) + 8'h01 || gain_level_o == $past(gain_level_o) - 8'h01
      || gain_level_o == 8'h00)
      else $error("gain jumped");
   a_gain_step_pace: assert property ($changed(gain_level_o) && gain_level_o != 8'h00 |=>
      $stable(gain_level_o) || gain_level_o == 8'h00)
      else $error("gain stepped too fast");
   a_mute_no_rise: assert property (!mute_n_i [*6] |-> gain_level_o <= $past(gain_level_o))
      else $error("gain rose while muted");
   a_standby_time: assert property (sb_cnt_ff <= SB_MAX)
      else $error("standby not reached in time");
   a_standby_quiet: assert property (standby_o |-> !sda_oe_o && chan_hiz_o == 4'hF && gain_level_o == 8'h00)
      else $error("standby left bus or channels active");
   a_por_pin_only: assert property (por_i [*5] |-> standby_o && fault_oe_o && !sda_oe_o)
      else $error("supply reset not shown on pin alone");
   a_master_sync: assert property ($stable(addr_sel_i) [*4] |-> osc_sync_master_o == (addr_sel_i == 2'b00))
      else $error("oscillator master role wrong");
   a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line changed with clock high");
endmodule // amp_mode_fault_sva

bind amp_mode_fault_pin_control amp_mode_fault_sva #(.STEP_CYC(STEP_CYC), .STBY_CYC(STBY_CYC)) u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
   .mute_n_i(mute_n_i), .standby_n_i(standby_n_i), .por_i(por_i), .uv_i(uv_i), .cp_uv_i(cp_uv_i),
   .ov_i(ov_i), .otsd_i(otsd_i), .fault_oe_o(fault_oe_o), .osc_sync_master_o(osc_sync_master_o),
   .chan_hiz_o(chan_hiz_o), .gain_level_o(gain_level_o), .standby_o(standby_o));
`default_nettype wire

// ===== amp_params.svh
/*
  Constants of the amplifier mode and fault supervisor: register offsets,
  field positions, reset values and timing figures.
  Assumes a 125 MHz system clock.
*/
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH

`define CLK_KHZ       125000
`define CM_RAMP_MS    26
`define GAIN_RAMP_MS  76
`define STBY_MS       1
`define GAIN_STEPS    255

`define DEV_ADDR_BASE 7'h6C
`define OFS_FAULT1    8'h00
`define OFS_FAULT2    8'h01
`define OFS_STAT1     8'h04
`define OFS_STAT2     8'h05
`define OFS_STAT3     8'h06
`define OFS_CTRL3     8'h0A
`define OFS_CTRL5     8'h0C

`define CTRL3_RST     8'h00
`define CTRL5_RST     8'h0F
`define FAULT_RST     8'h00
`define PINS_IDLE     23'h780000

`define C3_FSW        0
`define C3_CLIP_LSB   1
`define C3_TWEET      3
`define C5_CLR        7

`define F1_OV         7
`define F1_UV         6
`define F1_CPUV       4
`define F1_OTSD       3
`define F1_OC         2
`define F1_DC         1

`define S1_CLIP       0
`define S1_TWEET      1
`define S1_WARN       5
`define S1_FOLD       6

`endif

// ===== amp_pkg.sv
/*
  Types of the amplifier mode and fault supervisor.
  Assumes nothing beyond the constants header.
*/
package amp_pkg;

   typedef enum logic [1:0] {
      CLIP_WARN = 2'b00,
      CLIP_ONLY = 2'b01,
      CLIP_BOTH = 2'b10,
      CLIP_RSVD = 2'b11
   } clip_mode_t;

   typedef enum logic [2:0] {
      I_IDLE   = 3'b000,
      I_RX     = 3'b001,
      I_RX_ACK = 3'b010,
      I_TX     = 3'b011,
      I_TX_ACK = 3'b100
   } i2c_st_t;

   typedef enum logic [2:0] {
      R_OFF  = 3'b000,
      R_CM   = 3'b001,
      R_UP   = 3'b010,
      R_PLAY = 3'b011,
      R_DN   = 3'b100
   } ramp_st_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_wr_t;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic       mute_n;
      logic       stby_n;
      logic       por;
      logic       uv;
      logic       cp_uv;
      logic       ov;
      logic       otsd;
      logic       warn;
      logic       fold;
      logic       clip;
      logic       tweet;
      logic [3:0] oc;
      logic [3:0] dc;
      logic [1:0] addr_sel;
   } pins_t;

   typedef struct packed {
      i2c_st_t    st;
      logic       scl_p;
      logic       sda_p;
      logic       oe;
      logic       is_addr;
      logic       sub_pend;
      logic       rw;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] sub;
      reg_wr_t    wr;
   } slv_t;

endpackage

// ===== tb.sv
/*
  Self-checking bench of the amplifier mode and fault supervisor.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   import amp_pkg::*;
   logic       clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       mute_n = 1'b1;
   logic       stby_n = 1'b1;
   logic       por = 1'b0;
   logic [3:0] warn = 4'h0;   // Heat warning, clip, foldback, tweeter
   logic [5:0] flt = 6'h00;   // Ov, uv, cp_uv, otsd, oc ch1, dc ch2
   logic [1:0] asel = 2'b00;
   logic [7:0] dev_a = 8'hD8;
   logic       scl, h_oe, sda_oe, fault_oe, clip_oe, fsw, master, sb, ok, e;
   logic       sda_lo, flt_lo, clip_lo;
   logic [3:0] hiz;
   logic [7:0] gain;
   logic [7:0] q [$];
   logic [7:0] f1 [6] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02};
   logic [7:0] f2 [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h40};
   wire logic  sda;
   int         errors = 0;
   int         num_checks = 0;
   always #4 clk_i = ~clk_i;
   assign sda = !(h_oe | (sda_oe & ~sda_lo));
   amp_mode_fault_pin_control #(.CM_CYC(20), .STEP_CYC(2), .STBY_CYC(10)) u_amp_mode_fault_pin_control (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_lo), .sda_oe_o(sda_oe),
      .addr_sel_i(asel), .mute_n_i(mute_n), .standby_n_i(stby_n), .por_i(por), .uv_i(flt[1]),
      .cp_uv_i(flt[2]), .ov_i(flt[0]), .otsd_i(flt[3]), .heat_warning_i(warn[0]), .foldback_i(warn[2]),
      .clip_i(warn[1]), .tweeter_i(warn[3]), .oc_i({2'b00, flt[4], 1'b0}), .dc_i({1'b0, flt[5], 2'b00}),
      .fault_o(flt_lo), .fault_oe_o(fault_oe), .clip_heat_warn_pin_o(clip_lo), .clip_heat_warn_pin_oe_o(clip_oe),
      .fsw_500k_o(fsw), .osc_sync_master_o(master), .chan_hiz_o(hiz), .gain_level_o(gain), .standby_o(sb));
   amp_i2c_host u_amp_i2c_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
   task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] s);
      num_checks++;
      if (s !== ex)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, ex, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic await_sig(input logic is_gain, input logic [7:0] v);
      int i;
      for (i = 0; i < 3000; i++)
      begin
         if (is_gain ? gain === v : sb === v[0])
            break;
         @(negedge clk_i);
      end
      if (i == 3000)
      begin
         errors++;
         $display("wrong value wait expected %h seen timeout", v);
         tally_and_finish();
      end
   endtask
   task automatic bus_wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d [$], input logic ak);
      u_amp_i2c_host.wr(dev, sub, d, ok);
      chk("ack", {7'h00, ak}, {7'h00, ok});
   endtask
   task automatic bus_rd(input logic [7:0] sub, input logic [7:0] ex [$]);
      u_amp_i2c_host.rd(dev_a, sub, ex.size(), q, ok);
      chk("ack", 8'h01, {7'h00, ok});
      foreach (ex[i])
         chk("read", ex[i], q[i]);
   endtask
   task automatic settle();
      repeat (6) @(negedge clk_i);
   endtask
   initial
   begin
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      settle();
      chk("hiz", 8'h0F, {4'h0, hiz});
      chk("outs", 8'h00, {4'h0, fault_oe, clip_oe, fsw, sb});
      chk("pin lows", 8'h00, {5'h00, sda_lo, flt_lo, clip_lo});
      $display("test reset done");
      for (int a = 3; a >= 0; a--)
      begin
         asel = 2'(a);
         dev_a = 8'hD8 + 8'(2 * a);
         settle();
         chk("master", {7'h00, a == 0}, {7'h00, master});
         bus_wr(dev_a, 8'h0A, '{8'h01}, 1'b1);
         chk("fsw", 8'h01, {7'h00, fsw});
         bus_wr(8'hD8 + 8'(2 * ((a + 1) % 4)), 8'h0A, '{8'h00}, 1'b0);
         chk("fsw", 8'h01, {7'h00, fsw});
         bus_wr(dev_a, 8'h0A, '{8'h00}, 1'b1);
         chk("fsw", 8'h00, {7'h00, fsw});
      end
      $display("test address done");
      bus_wr(dev_a, 8'h0A, '{8'h01, 8'h55, 8'h00}, 1'b1);
      bus_rd(8'h0A, '{8'h01, 8'h00, 8'h00});
      await_sig(1'b1, 8'hFF);
      bus_rd(8'h05, '{8'h00, 8'hFF});
      mute_n = 1'b0;
      await_sig(1'b1, 8'h00);
      mute_n = 1'b1;
      await_sig(1'b1, 8'hFF);
      $display("test ramp done");
      for (int m = 0; m < 4; m++)
      begin
         bus_wr(dev_a, 8'h0A, '{8'(m << 1)}, 1'b1);
         for (int i = 0; i < 8; i++)
         begin
            warn = 4'(i);
            settle();
            e = m == 1 ? warn[1] : m == 2 ? warn[0] | warn[1] | warn[2] : warn[0] | warn[2];
            chk("clip pin", {7'h00, e}, {7'h00, clip_oe});
         end
      end
      bus_wr(dev_a, 8'h0A, '{8'h08}, 1'b1);
      warn = 4'h8;
      settle();
      chk("clip pin", 8'h01, {7'h00, clip_oe});
      warn = 4'h7;
      settle();
      bus_rd(8'h04, '{8'h61});
      warn = 4'h0;
      $display("test warning pin done");
      for (int k = 0; k < 6; k++)
      begin
         flt = 6'(1 << k);
         settle();
         chk("fault pin", 8'h01, {7'h00, fault_oe});
         chk("hiz", k < 4 ? 8'h0F : 8'(2 << (k - 4)), {4'h0, hiz});
         flt = 6'h00;
         settle();
         chk("fault pin", 8'h01, {7'h00, fault_oe});
         bus_rd(8'h00, '{f1[k], f2[k]});
         bus_wr(dev_a, 8'h0C, '{8'h80}, 1'b1);
         chk("fault pin", 8'h00, {7'h00, fault_oe});
      end
      por = 1'b1;
      settle();
      chk("por pins", 8'h03, {6'h00, fault_oe, sb});
      bus_wr(dev_a, 8'h0A, '{8'h01}, 1'b0);
      por = 1'b0;
      settle();
      chk("fault pin", 8'h00, {7'h00, fault_oe});
      $display("test faults done");
      bus_wr(dev_a, 8'h0A, '{8'h01, 8'h00, 8'h00}, 1'b1);
      await_sig(1'b1, 8'hFF);
      stby_n = 1'b0;
      await_sig(1'b0, 8'h01);
      chk("standby", 8'h0F, {3'h0, fsw, hiz});
      bus_wr(dev_a, 8'h0A, '{8'h01}, 1'b0);
      stby_n = 1'b1;
      settle();
      bus_rd(8'h0A, '{8'h00});
      $display("test standby done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
